// ===== dsc_conv_ctrl.sv
// conversion sequencing and serial result output of a dual sampling converter
`timescale 1ns/1ps
// Function
// - Channel-count pin picks two or four channel mode; four toggles pair itself.
// - Routing pin picks both lines at once or both results on line A.
// - Two-channel mode latches pair select in cycle one for next conversion.
// - A conversion takes exactly 20 clock cycles in dual-line mode and 40 in single-line mode.
// - Start rising edge puts both samplers into hold at once.
// - Busy is high for the whole conversion cycle.
// - Start and read only count while chip select is low.
// - Every frame bit is valid across its whole clock cycle.
// - Frame: pair flag, converter flag, sixteen result bits msb first, two zeros.
// - Pair flag only in four-channel mode; converter flag only in single-line mode.
// - Single-line mode floats line B after the next conversion.
// - Single-line mode shifts both results on line A over 40 cycles.
// - With routing high, a start inside the 40-cycle frame is ignored.
// - Four-channel dual-line alternates pairs and drives both lines.
// - Separate read strobe: data valid after third rising edge after its rise.
// - A start while idle begins conversion on the third rising edge after its rise.
module dsc_conv_ctrl
   import dsc_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic        convert_start_strobe_i,
   input  wire logic        read_strobe_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        channel_count_select_i,
   input  wire logic        output_routing_select_i,
   input  wire logic        pair_select_i,
   input  wire logic [15:0] result_a_i,
   input  wire logic [15:0] result_b_i,
   output logic             hold_o,
   output logic             busy_o,
   output logic             pair_o,
   output logic             serial_a_o,
   output logic             serial_a_oe_o,
   output logic             serial_b_o,
   output logic             serial_b_oe_o
);
   // two-flop synchronisers for all pin inputs
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic       start_s, read_s, cs_n_s, four_s, single_s, pair_sel_s;
   logic       start_d_reg, read_d_reg;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg   <= 6'h04;
         sync2_reg   <= 6'h04;
         start_d_reg <= 1'b0;
         read_d_reg  <= 1'b0;
      end else begin
         sync1_reg   <= {pair_select_i, output_routing_select_i, channel_count_select_i,
                         chip_select_n_i, read_strobe_i, convert_start_strobe_i};
         sync2_reg   <= sync1_reg;
         start_d_reg <= sync2_reg[0];
         read_d_reg  <= sync2_reg[1];
      end
   end

   assign start_s    = sync2_reg[0];
   assign read_s     = sync2_reg[1];
   assign cs_n_s     = sync2_reg[2];
   assign four_s     = sync2_reg[3];
   assign single_s   = sync2_reg[4];
   assign pair_sel_s = sync2_reg[5];

   // conversion state
   dsc_state_t  state_reg, state_next;
   logic [5:0]  cyc_reg, cyc_next;
   logic        single_reg, single_next;
   logic        four_reg, four_next;
   logic        pair_reg, pair_next;
   logic        pair_sel_reg, pair_sel_next;
   logic [15:0] res_a_reg, res_a_next;
   logic [15:0] res_b_reg, res_b_next;
   logic        b_oe_reg, b_oe_next;
   logic        start_ok, read_rise, last_cyc;

   assign start_ok  = start_s & ~start_d_reg & ~cs_n_s;
   assign read_rise = read_s & ~read_d_reg & ~cs_n_s;
   assign last_cyc  = single_reg ? (cyc_reg == CYC_DOUBLE_LAST)
                                 : (cyc_reg == CYC_SINGLE_LAST);

   // sequencer next values
   always_comb begin
      state_next    = state_reg;
      cyc_next      = cyc_reg;
      single_next   = single_reg;
      four_next     = four_reg;
      pair_next     = pair_reg;
      pair_sel_next = pair_sel_reg;
      res_a_next    = res_a_reg;
      res_b_next    = res_b_reg;
      b_oe_next     = b_oe_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_ok) begin
               state_next  = ST_CONVERT;
               cyc_next    = CYC_FIRST;
               single_next = single_s;
               four_next   = four_s;
               res_a_next  = result_a_i;
               res_b_next  = result_b_i;
               if (four_s) begin
                  pair_next = ~pair_reg;
               end else begin
                  pair_next = pair_sel_reg;
               end
               if (!single_s) begin
                  b_oe_next = 1'b1;
               end
            end
         end
         ST_CONVERT: begin
            if (cyc_reg == CYC_FIRST) begin
               pair_sel_next = pair_sel_s;
            end
            if (last_cyc) begin
               state_next = ST_IDLE;
               cyc_next   = CYC_IDLE;
               if (single_reg) begin
                  b_oe_next = 1'b0;
               end
            end else begin
               cyc_next = cyc_reg + 6'h01;
            end
         end
         default: begin
            state_next = ST_IDLE;
            cyc_next   = CYC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg    <= ST_IDLE;
         cyc_reg      <= CYC_IDLE;
         single_reg   <= 1'b0;
         four_reg     <= 1'b0;
         pair_reg     <= 1'b0;
         pair_sel_reg <= 1'b0;
         res_a_reg    <= RESULT_RST;
         res_b_reg    <= RESULT_RST;
         b_oe_reg     <= 1'b1;
      end else begin
         state_reg    <= state_next;
         cyc_reg      <= cyc_next;
         single_reg   <= single_next;
         four_reg     <= four_next;
         pair_reg     <= pair_next;
         pair_sel_reg <= pair_sel_next;
         res_a_reg    <= res_a_next;
         res_b_reg    <= res_b_next;
         b_oe_reg     <= b_oe_next;
      end
   end

   // read strobe arming: valid at third edge after the rise
   logic [4:0] rd_cnt_reg, rd_cnt_next;
   logic       rd_ok_reg, rd_ok_next;

   always_comb begin
      rd_cnt_next = rd_cnt_reg;
      rd_ok_next  = rd_ok_reg;
      if (read_rise) begin
         rd_cnt_next = READ_DELAY;
         rd_ok_next  = 1'b1;
      end else if (rd_cnt_reg != 5'h00) begin
         rd_cnt_next = rd_cnt_reg - 5'h01;
         rd_ok_next  = 1'b1;
      end else if (state_reg == ST_CONVERT && last_cyc) begin
         rd_ok_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_cnt_reg <= 5'h00;
         rd_ok_reg  <= 1'b0;
      end else begin
         rd_cnt_reg <= rd_cnt_next;
         rd_ok_reg  <= rd_ok_next;
      end
   end

   // frame formatters for line A and line B
   dsc_frame_if fa ();
   dsc_frame_if fb ();
   logic       second_half;
   logic [5:0] idx_a;

   assign second_half  = single_next && (cyc_next > CYC_SINGLE_LAST);
   assign idx_a        = second_half ? cyc_next - CYC_SINGLE_LAST : cyc_next;
   assign fa.bit_index = idx_a[4:0];
   assign fa.pair_flag = four_next & pair_next;
   assign fa.conv_flag = second_half;
   assign fa.result    = second_half ? res_b_next : res_a_next;
   assign fb.bit_index = cyc_next[4:0];
   assign fb.pair_flag = four_next & pair_next;
   assign fb.conv_flag = 1'b0;
   assign fb.result    = res_b_next;

   dsc_frame_bit u_fmt_a (.fr(fa));
   dsc_frame_bit u_fmt_b (.fr(fb));

   // registered serial data, steady for the whole clock cycle
   logic ser_a_reg, ser_a_next, ser_b_reg, ser_b_next;

   always_comb begin
      ser_a_next = 1'b0;
      ser_b_next = 1'b0;
      if (state_next == ST_CONVERT && rd_ok_next) begin
         ser_a_next = fa.frame_bit;
         ser_b_next = fb.frame_bit & ~single_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ser_a_reg <= 1'b0;
         ser_b_reg <= 1'b0;
      end else begin
         ser_a_reg <= ser_a_next;
         ser_b_reg <= ser_b_next;
      end
   end

   // outputs
   assign hold_o = (convert_start_strobe_i & ~chip_select_n_i) | (state_reg == ST_CONVERT);
   assign busy_o        = (state_reg == ST_CONVERT);
   assign pair_o        = pair_reg;
   assign serial_a_o    = ser_a_reg;
   assign serial_a_oe_o = 1'b1;
   assign serial_b_o    = ser_b_reg;
   assign serial_b_oe_o = b_oe_reg;
endmodule

// ===== dsc_conv_ctrl_sva.sv
// port assertions for the conversion control block
`timescale 1ns/1ps
module dsc_conv_ctrl_sva
   import dsc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic convert_start_strobe_i,
   input wire logic chip_select_n_i,
   input wire logic channel_count_select_i,
   input wire logic output_routing_select_i,
   input wire logic hold_o,
   input wire logic busy_o,
   input wire logic pair_o,
   input wire logic serial_a_o,
   input wire logic serial_b_o,
   input wire logic serial_b_oe_o
);
   logic [5:0] busy_cnt_reg;
   // counts cycles with busy high
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_cnt_reg <= 6'h00;
      end else begin
         busy_cnt_reg <= busy_o ? busy_cnt_reg + 6'h01 : 6'h00;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   property p_len;
      $fell(busy_o) |-> busy_cnt_reg == CYC_SINGLE_LAST || busy_cnt_reg == CYC_DOUBLE_LAST;
   endproperty
   a_len: assert property (p_len) else $error("busy length");
   property p_hold;
      (convert_start_strobe_i && !chip_select_n_i) || busy_o |-> hold_o;
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_busy;
      $rose(busy_o) |-> busy_o [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("busy short");
   property p_start;
      $rose(busy_o) |-> $past(convert_start_strobe_i, 3) && !$past(chip_select_n_i, 3);
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_gap;
      $fell(busy_o) |-> !busy_o [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("busy again");
   property p_tail;
      $fell(busy_o) |-> !$past(serial_a_o, 1) && !$past(serial_a_o, 2) && !$past(serial_b_o, 1);
   endproperty
   a_tail: assert property (p_tail) else $error("tail not zero");
   property p_cflag;
      $rose(busy_o) && !output_routing_select_i |-> ##1 !serial_a_o && !serial_b_o;
   endproperty
   a_cflag: assert property (p_cflag) else $error("conv flag");
   property p_pflag;
      $rose(busy_o) |-> serial_a_o == (channel_count_select_i & pair_o);
   endproperty
   a_pflag: assert property (p_pflag) else $error("pair flag");
   property p_boe;
      $fell(busy_o) && output_routing_select_i |-> ##[0:2] !serial_b_oe_o;
   endproperty
   a_boe: assert property (p_boe) else $error("line b driven");
endmodule
bind dsc_conv_ctrl dsc_conv_ctrl_sva u_sva (
   .clk_sys_i               (clk_sys_i),
   .rstn_i                  (rstn_i),
   .convert_start_strobe_i  (convert_start_strobe_i),
   .chip_select_n_i         (chip_select_n_i),
   .channel_count_select_i  (channel_count_select_i),
   .output_routing_select_i (output_routing_select_i),
   .hold_o                  (hold_o),
   .busy_o                  (busy_o),
   .pair_o                  (pair_o),
   .serial_a_o              (serial_a_o),
   .serial_b_o              (serial_b_o),
   .serial_b_oe_o           (serial_b_oe_o)
);

// ===== dsc_conv_ctrl_tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module dsc_conv_ctrl_tb
   import dsc_pkg::*;
;
   typedef struct packed {logic [5:0] n; logic [39:0] a; logic [19:0] b;} dsc_exp_t;
   logic        clk_sys_i = 1'b0, rstn_i = 1'b0, convert_start_strobe_i = 1'b0;
   logic        chip_select_n_i = 1'b0, channel_count_select_i = 1'b0;
   logic        output_routing_select_i = 1'b0, pair_select_i = 1'b0;
   logic [15:0] result_a_i = 16'h0000, result_b_i = 16'h0000;
   logic        hold_o, busy_o, pair_o, serial_a_o, serial_a_oe_o, serial_b_o, serial_b_oe_o;
   logic        done;
   logic        prev_ps;
   logic [5:0]  nb;
   logic [39:0] ba;
   logic [19:0] bb;
   integer      seed = 16322, err_count = 0, samples_checked = 0, i;
   dsc_exp_t    q[$];
   wire         read_strobe_i = convert_start_strobe_i;
   always #50 clk_sys_i = ~clk_sys_i;
   dsc_conv_ctrl dut (
      .clk_sys_i               (clk_sys_i),
      .rstn_i                  (rstn_i),
      .convert_start_strobe_i  (convert_start_strobe_i),
      .read_strobe_i           (read_strobe_i),
      .chip_select_n_i         (chip_select_n_i),
      .channel_count_select_i  (channel_count_select_i),
      .output_routing_select_i (output_routing_select_i),
      .pair_select_i           (pair_select_i),
      .result_a_i              (result_a_i),
      .result_b_i              (result_b_i),
      .hold_o                  (hold_o),
      .busy_o                  (busy_o),
      .pair_o                  (pair_o),
      .serial_a_o              (serial_a_o),
      .serial_a_oe_o           (serial_a_oe_o),
      .serial_b_o              (serial_b_o),
      .serial_b_oe_o           (serial_b_oe_o)
   );
   dsc_host_model host (.clk_i(clk_sys_i), .busy_i(busy_o), .ser_a_i(serial_a_o),
      .ser_b_i(serial_b_o), .ser_b_oe_i(serial_b_oe_o), .done_o(done), .nbits_o(nb),
      .bits_a_o(ba), .bits_b_o(bb));
   // compare helpers
   task automatic chk_frame(input logic [65:0] e, input logic [65:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_bit(input logic e, input logic g);
      chk_frame({65'h0, e}, {65'h0, g});
   endtask
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // start strobe held three cycles
   task automatic pulse;
      convert_start_strobe_i = 1'b1;
      @(negedge clk_sys_i);
      chk_bit(~chip_select_n_i, hold_o);
      repeat (2) @(negedge clk_sys_i);
      convert_start_strobe_i = 1'b0;
   endtask
   // one conversion: note the frame, strobe, wait for busy to drop
   task automatic conv(input logic pf, input logic twice, input logic first_cv);
      dsc_exp_t e;
      result_a_i = 16'($random(seed));
      result_b_i = 16'($random(seed));
      e.n = output_routing_select_i ? CYC_DOUBLE_LAST : CYC_SINGLE_LAST;
      e.a = output_routing_select_i ? {pf, 1'b0, result_a_i, 2'b00, pf, 1'b1, result_b_i, 2'b00}
                                    : {20'h00000, pf, 1'b0, result_a_i, 2'b00};
      e.b = output_routing_select_i ? (first_cv ? 20'h00000 : 20'hfffff)
                                    : {pf, 1'b0, result_b_i, 2'b00};
      q.push_back(e);
      pulse;
      if (twice) begin
         repeat (10) @(negedge clk_sys_i);
         pulse;
      end
      for (i = 0; i < 60 && busy_o === 1'b1; i++) @(negedge clk_sys_i);
      chk_bit(1'b0, busy_o);
      repeat (3) @(negedge clk_sys_i);
      chk_bit(!output_routing_select_i, serial_b_oe_o);
      chk_bit(1'b1, serial_a_oe_o);
   endtask
   // each finished frame against the oldest note
   always @(posedge clk_sys_i) begin
      if (done === 1'b1) chk_frame(q.pop_front(), {nb, ba, bb});
   end
   // all four modes, each after a fresh reset
   initial begin
      repeat (7) @(negedge clk_sys_i);
      for (int m = 0; m < 4; m++) begin
         rstn_i = 1'b0;
         channel_count_select_i = m[1];
         output_routing_select_i = m[0];
         pair_select_i = 1'($random(seed));
         @(negedge clk_sys_i);
         rstn_i = 1'b1;
         for (int k = 1; k < 4; k++) begin
            @(negedge clk_sys_i);
            prev_ps = pair_select_i;
            pair_select_i = 1'($random(seed));
            conv(channel_count_select_i & k[0], k == 2, k == 1);
            if (k > 1) chk_bit(channel_count_select_i ? k[0] : prev_ps, pair_o);
         end
      end
      chip_select_n_i = 1'b1;
      pulse;
      repeat (3) @(negedge clk_sys_i);
      chk_bit(1'b0, busy_o);
      chk_frame(66'h0, 66'(q.size()));
      stop_test;
   end
   // watchdog
   initial begin
      #400000;
      err_count++;
      stop_test;
   end
endmodule

// ===== dsc_frame_bit.sv
// picks one bit of a 20-bit result frame by its cycle position
`timescale 1ns/1ps
module dsc_frame_bit
   import dsc_pkg::*;
(
   dsc_frame_if.fmt fr
);
   logic [4:0] msb_dist;

   // flags, msb first result, then trailing zeros
   always_comb begin
      msb_dist = fr.bit_index - BIT_MSB;
      if (fr.bit_index == BIT_PAIR_FLAG) begin
         fr.frame_bit = fr.pair_flag;
      end else if (fr.bit_index == BIT_CONV_FLAG) begin
         fr.frame_bit = fr.conv_flag;
      end else if (fr.bit_index >= BIT_MSB && fr.bit_index <= BIT_LSB) begin
         fr.frame_bit = fr.result[4'(4'hf - msb_dist[3:0])];
      end else begin
         fr.frame_bit = 1'b0;
      end
   end
endmodule

// ===== dsc_frame_if.sv
// one serial frame position and its payload, with the bit it yields
`timescale 1ns/1ps
interface dsc_frame_if;
   logic [4:0]  bit_index;
   logic        pair_flag;
   logic        conv_flag;
   logic [15:0] result;
   logic        frame_bit;
   modport ctrl (output bit_index, output pair_flag, output conv_flag, output result,
                 input frame_bit);
   modport fmt  (input bit_index, input pair_flag, input conv_flag, input result,
                 output frame_bit);
endinterface

// ===== dsc_host_model.sv
// host side receiver gathering serial frames
`timescale 1ns/1ps
module dsc_host_model (
   input  wire logic  clk_i,
   input  wire logic  busy_i,
   input  wire logic  ser_a_i,
   input  wire logic  ser_b_i,
   input  wire logic  ser_b_oe_i,
   output logic       done_o,
   output logic [5:0] nbits_o,
   output logic [39:0] bits_a_o,
   output logic [19:0] bits_b_o
);
   logic [5:0]  cnt = 6'h00;
   logic [39:0] sh_a = 40'h0;
   logic [19:0] sh_b = 20'h0;
   // capture on falling edges while busy, report when busy drops
   always @(negedge clk_i) begin
      done_o <= 1'b0;
      if (busy_i) begin
         sh_a <= {sh_a[38:0], ser_a_i};
         sh_b <= {sh_b[18:0], ser_b_oe_i ? ser_b_i : 1'b1}; // released line reads ones
         cnt <= cnt + 6'h01;
      end else if (cnt != 6'h00) begin
         {done_o, nbits_o, bits_a_o, bits_b_o} <= {1'b1, cnt, sh_a, sh_b};
         {cnt, sh_a, sh_b} <= 66'h0;
      end
   end
endmodule

// ===== dsc_pkg.sv
// constants and types shared by the conversion control block
package dsc_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned RESULT_W        = 16;
   localparam int unsigned FRAME_CYCLES    = 20;
   localparam int unsigned DUAL_FRAME_CYC  = 40;
   localparam int unsigned CYC_W           = 6;
   localparam logic [5:0]  CYC_IDLE        = 6'h00;
   localparam logic [5:0]  CYC_FIRST       = 6'h01;
   localparam logic [5:0]  CYC_SINGLE_LAST = 6'h14;
   localparam logic [5:0]  CYC_DOUBLE_LAST = 6'h28;
   localparam logic [4:0]  BIT_PAIR_FLAG   = 5'h01;
   localparam logic [4:0]  BIT_CONV_FLAG   = 5'h02;
   localparam logic [4:0]  BIT_MSB         = 5'h03;
   localparam logic [4:0]  BIT_LSB         = 5'h12;
   localparam logic [4:0]  READ_DELAY      = 5'h01;
   localparam logic [15:0] RESULT_RST      = 16'h0000;
   typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} dsc_state_t;
endpackage
